// File: cpsp_pkg.sv
/*
 * constants for the control port with slave-port status: register
 * indices, field positions, reset values and codes.
 * assumes a byte-wide register port with a 3-bit word address.
 */
package cpsp_pkg;
    // ==========================================================
    // register addresses
    localparam logic [2:0] ADDR_PIN_LEVEL = 3'h0;
    localparam logic [2:0] ADDR_OUT_LATCH = 3'h1;
    localparam logic [2:0] ADDR_DIR_PSP = 3'h2;
    localparam logic [2:0] ADDR_AN_CFG = 3'h3;
    localparam logic [2:0] ADDR_PSP_DATA = 3'h4;

    // ==========================================================
    // direction and slave-port register fields
    localparam int DIR_IBF_BIT = 7;
    localparam int DIR_OBF_BIT = 6;
    localparam int DIR_INPUT_OVERFLOW_FLAG_BIT = 5;
    localparam int DIR_MODE_BIT = 4;
    localparam int PIN3_BIT = 3;
    localparam logic [2:0] DIR_RESET = 3'h7;
    localparam logic [2:0] LATCH_RESET = 3'h0;

    // ==========================================================
    // analog configuration: low six bits writable
    localparam logic [7:0] AN_CFG_MASK = 8'h3F;
    localparam logic [7:0] AN_CFG_RESET = 8'h00;
    localparam logic [3:0] AN_DIGITAL_MIN = 4'hA;

    // ==========================================================
    // synchroniser depth
    localparam int SYNC_STAGES = 2;
endpackage

// File: cpsp_sync.sv
/*
 * two-flop synchroniser for a bus of independent level inputs.
 * assumes each bit is an unrelated level; no word coherence.
 */
`timescale 1ns/1ps
module cpsp_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // reset to the idle-high pin level: a zero here would show a false
    // master-clear request and a false low strobe right after reset
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            meta_q <= '1;
            sync_q <= '1;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule

// File: cpsp_strobe.sv
/*
 * start/end pulse detector for a qualified strobe level.
 * assumes the level is already synchronised to ref_clk.
 */
`timescale 1ns/1ps
module cpsp_strobe (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // strobe
    input wire logic active,
    output logic start_pulse,
    output logic end_pulse
);
    logic active_q;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            active_q <= 1'b0;
        end else begin
            active_q <= active;
        end
    end

    assign start_pulse = active & ~active_q;
    assign end_pulse = ~active & active_q;
endmodule

// File: cpsp_top.sv
/*
 * control port: three configurable pins with direction, latch and
 * analog sharing, an input-only pin shared with master clear, and
 * the slave-port strobe decode with its buffer status flags.
 * assumes pins and the external data bus are asynchronous, and that
 * master_clear_select and small_package are static configuration
 * levels from logic on ref_clk.
 */
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ps

// What this block does
// - direction bit one: pin is input, driver off
// - direction bit zero: pin drives its latch bit
// - analog-selected pins read zero in the pin level register
// - direction bits still drive outputs while pins are analog
// - after reset all three pins are selected analog
// - latch register reads the latch, not the pins
// - pin 3 input only; digital when select is 0, else master clear
// - small package: only pin 3, only when master clear disabled
// - pin 3 bit only without master clear; upper bits read zero
// - input-full flag read-only, set while a word waits unread
// - output-full flag read-only, set until the word is read out
// - overflow set on write into unread buffer; cleared by writing 0
// - mode bit selects slave-port operation when set
// - unimplemented bits read zero and ignore writes
// - slave mode with inputs: pin 0 read strobe, pin 1 write strobe
// - analog selection blocks pin level reads, not strobes or latch output
// - end of an external write sets irq and input-full flags
// - external read presents data and clears output-full
module cpsp_top (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // register port
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // configuration levels
    input wire logic master_clear_select,
    input wire logic small_package,
    // configurable pins
    input wire logic [2:0] ctrl_pin_in,
    output logic [2:0] ctrl_pin_out,
    output logic [2:0] ctrl_pin_oe_n,
    // input-only pin
    input wire logic ctrl_pin_3,
    output logic master_clear_req,
    // slave-port data bus
    input wire logic [7:0] psp_data_in,
    output logic [7:0] psp_data_out,
    output logic [7:0] psp_data_oe_n,
    // events
    output logic slave_port_irq_flag
);
    // ==========================================================
    // state
    logic [2:0] dir_q;
    logic [2:0] latch_q;
    logic [7:0] an_cfg_q;
    logic mode_q;
    logic ibf_q;
    logic obf_q;
    logic input_overflow_flag_q;
    logic [7:0] in_word_q;
    logic [7:0] out_word_q;
    logic [7:0] rdata_q;

    logic [2:0] pin_s;
    logic pin3_s;
    logic [7:0] data_s;
    logic [2:0] analog;
    logic psp_en;
    logic wr_active;
    logic rd_active;
    logic wr_start;
    logic wr_end;
    logic rd_start;
    logic rd_end;
    logic pin3_live;
    logic rd_data_reg;
    logic wr_data_reg;

    function automatic logic hit(input logic [2:0] a, input logic [2:0] r);
        return a == r;
    endfunction

    // ==========================================================
    // pin synchronisers
    cpsp_sync #(.WIDTH(4)) u_pin_sync (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .async_in({ctrl_pin_3, ctrl_pin_in}),
        .sync_out({pin3_s, pin_s})
    );

    cpsp_sync #(.WIDTH(8)) u_data_sync (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .async_in(psp_data_in),
        .sync_out(data_s)
    );

    // ==========================================================
    // analog selection and pin drivers
    // all three pins go analog together below the digital threshold
    assign analog = (an_cfg_q[3:0] < cpsp_pkg::AN_DIGITAL_MIN) ? 3'h7 : 3'h0;

    // driver follows direction alone, analog or not; the small
    // package has no such pins so drivers stay off there
    assign ctrl_pin_oe_n = small_package ? 3'h7 : dir_q;
    assign ctrl_pin_out = latch_q;

    // ==========================================================
    // input-only pin and master clear
    assign pin3_live = ~master_clear_select;
    assign master_clear_req = master_clear_select & ~pin3_s;

    // ==========================================================
    // slave-port strobe decode
    // strobes use the pin path directly: the TTL buffer is not gated
    // by analog selection
    assign psp_en = mode_q & (&dir_q) & ~small_package;
    assign wr_active = psp_en & ~pin_s[2] & ~pin_s[1];
    assign rd_active = psp_en & ~pin_s[2] & ~pin_s[0];

    cpsp_strobe u_wr_strobe (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .active(wr_active),
        .start_pulse(wr_start),
        .end_pulse(wr_end)
    );

    cpsp_strobe u_rd_strobe (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .active(rd_active),
        .start_pulse(rd_start),
        .end_pulse(rd_end)
    );

    assign slave_port_irq_flag = wr_end | rd_end;
    assign psp_data_out = out_word_q;
    assign psp_data_oe_n = rd_active ? 8'h00 : 8'hFF;

    assign rd_data_reg = reg_rd & hit(reg_addr, cpsp_pkg::ADDR_PSP_DATA);
    assign wr_data_reg = reg_wr & hit(reg_addr, cpsp_pkg::ADDR_PSP_DATA);

    // ==========================================================
    // software-written configuration
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            dir_q <= cpsp_pkg::DIR_RESET;
            mode_q <= 1'b0;
        end else if (reg_wr && hit(reg_addr, cpsp_pkg::ADDR_DIR_PSP)) begin
            dir_q <= reg_wdata[2:0];
            mode_q <= reg_wdata[cpsp_pkg::DIR_MODE_BIT];
        end
    end

    // writes to the pin level register land in the latch
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            latch_q <= cpsp_pkg::LATCH_RESET;
        end else if (reg_wr && (hit(reg_addr, cpsp_pkg::ADDR_OUT_LATCH)
                     || hit(reg_addr, cpsp_pkg::ADDR_PIN_LEVEL))) begin
            latch_q <= reg_wdata[2:0];
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            an_cfg_q <= cpsp_pkg::AN_CFG_RESET;
        end else if (reg_wr && hit(reg_addr, cpsp_pkg::ADDR_AN_CFG)) begin
            an_cfg_q <= reg_wdata & cpsp_pkg::AN_CFG_MASK;
        end
    end

    // ==========================================================
    // buffer status flags
    // a write ending as software reads the word sets the flag again
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ibf_q <= 1'b0;
        end else if (wr_end) begin
            ibf_q <= 1'b1;
        end else if (rd_data_reg) begin
            ibf_q <= 1'b0;
        end
    end

    // an overflowing word is dropped so the unread one survives
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            in_word_q <= 8'h00;
        end else if (wr_active && !ibf_q) begin
            in_word_q <= data_s;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            input_overflow_flag_q <= 1'b0;
        end else if (wr_end && ibf_q) begin
            input_overflow_flag_q <= 1'b1;
        end else if (reg_wr && hit(reg_addr, cpsp_pkg::ADDR_DIR_PSP)
                     && !reg_wdata[cpsp_pkg::DIR_INPUT_OVERFLOW_FLAG_BIT]) begin
            input_overflow_flag_q <= 1'b0;
        end
    end

    // a software write during an external read is read out at once
    // and does not set the flag
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            obf_q <= 1'b0;
        end else if (rd_start || rd_active) begin
            obf_q <= 1'b0;
        end else if (wr_data_reg) begin
            obf_q <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            out_word_q <= 8'h00;
        end else if (wr_data_reg) begin
            out_word_q <= reg_wdata;
        end
    end

    // ==========================================================
    // register read-back, one cycle after the strobe
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                cpsp_pkg::ADDR_PIN_LEVEL: begin
                    rdata_q <= {4'h0, pin3_s & pin3_live,
                                small_package ? 3'h0 : pin_s & ~analog};
                end
                cpsp_pkg::ADDR_OUT_LATCH: begin
                    rdata_q <= {5'h00, small_package ? 3'h0 : latch_q};
                end
                cpsp_pkg::ADDR_DIR_PSP: begin
                    rdata_q <= {ibf_q, obf_q, input_overflow_flag_q, mode_q, 1'b0, dir_q};
                end
                cpsp_pkg::ADDR_AN_CFG: begin
                    rdata_q <= an_cfg_q;
                end
                cpsp_pkg::ADDR_PSP_DATA: begin
                    rdata_q <= in_word_q;
                end
                default: begin
                    rdata_q <= 8'h00;
                end
            endcase
        end
    end

    assign reg_rdata = rdata_q;

    // ==========================================================
    // checks
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    dir_input_a: assert property (
        dir_q[0] && dir_q[1] && dir_q[2] |-> ctrl_pin_oe_n == 3'h7)
        else $error("input pins are driven");

    latch_drive_a: assert property (
        reg_wr && hit(reg_addr, cpsp_pkg::ADDR_OUT_LATCH)
        |=> ctrl_pin_out == $past(reg_wdata[2:0]))
        else $error("output pins do not follow the latch");

    out_enable_a: assert property (
        !small_package |-> ctrl_pin_oe_n == dir_q)
        else $error("driver enable does not follow direction");

    digital_read_a: assert property (
        reg_rd && hit(reg_addr, cpsp_pkg::ADDR_PIN_LEVEL) && analog == 3'h0 && !small_package
        |=> reg_rdata[2:0] == $past(pin_s))
        else $error("digital pins read wrong level");

    mode_write_a: assert property (
        reg_wr && hit(reg_addr, cpsp_pkg::ADDR_DIR_PSP)
        |=> mode_q == $past(reg_wdata[cpsp_pkg::DIR_MODE_BIT]))
        else $error("mode bit not written");

    analog_read_a: assert property (
        reg_rd && hit(reg_addr, cpsp_pkg::ADDR_PIN_LEVEL) && analog == 3'h7
        |=> reg_rdata[2:0] == 3'h0)
        else $error("analog pins read nonzero");

    latch_read_a: assert property (
        reg_rd && hit(reg_addr, cpsp_pkg::ADDR_OUT_LATCH) && !small_package
        |=> reg_rdata[2:0] == $past(latch_q))
        else $error("latch read does not return latch");

    rsvd_zero_a: assert property (
        reg_rd && hit(reg_addr, cpsp_pkg::ADDR_DIR_PSP)
        |=> !reg_rdata[cpsp_pkg::PIN3_BIT])
        else $error("reserved direction bit reads one");

    ibf_set_a: assert property (
        wr_end |=> ibf_q)
        else $error("write end did not set input full");

    irq_pulse_a: assert property (
        wr_end |-> slave_port_irq_flag)
        else $error("write end did not raise irq");

    flag_ro_a: assert property (
        reg_wr && hit(reg_addr, cpsp_pkg::ADDR_DIR_PSP) && !wr_end && !rd_start
        && !rd_active && !rd_data_reg |=> ibf_q == $past(ibf_q) && obf_q == $past(obf_q))
        else $error("status flags changed by software write");

    ovf_clear_a: assert property (
        reg_wr && hit(reg_addr, cpsp_pkg::ADDR_DIR_PSP)
        && !reg_wdata[cpsp_pkg::DIR_INPUT_OVERFLOW_FLAG_BIT] && !wr_end |=> !input_overflow_flag_q)
        else $error("overflow not cleared by writing zero");

    obf_set_a: assert property (
        wr_data_reg && !rd_start && !rd_active |=> obf_q)
        else $error("data write did not set output full");

    ovf_set_a: assert property (
        wr_end && ibf_q |=> input_overflow_flag_q [*2] or
        (input_overflow_flag_q ##1 $fell(input_overflow_flag_q) && $past(reg_wr)))
        else $error("overflow not set or lost");

    obf_clear_a: assert property (
        rd_start |-> ##[1:2] !obf_q && psp_data_oe_n != 8'hFF || rd_end)
        else $error("read did not clear output full");

    ibf_clear_a: assert property (
        rd_data_reg && !wr_end |=> !ibf_q)
        else $error("data read did not clear input full");

    master_clear_input_a: assert property (
        master_clear_select && $fell(pin3_s) |-> master_clear_req)
        else $error("master clear not raised");
endmodule

// File: cpsp_ext_cpu.sv
/*
 * far side of the control port: an external processor driving the
 * read, write and chip-select strobes and the shared data bus.
 * assumes the testbench calls its tasks and sets idle pin levels.
 */
`timescale 1ns/1ps
module cpsp_ext_cpu (
    // clock
    input wire logic ref_clk,
    // device drivers
    input wire logic [2:0] pin_out,
    input wire logic [2:0] pin_oe_n,
    input wire logic [7:0] bus_out,
    input wire logic [7:0] bus_oe_n,
    // resolved wire levels
    output logic [2:0] pin_lvl,
    output logic [7:0] bus_lvl
);
    // ==========================================================
    // wire resolution, {cs, wr, rd} when strobing
    logic [2:0] lvl = 3'h7;
    logic [7:0] drv = 8'h00;
    assign pin_lvl = (pin_out & ~pin_oe_n) | (lvl & pin_oe_n);
    assign bus_lvl = (bus_out & ~bus_oe_n) | (drv & bus_oe_n);

    // ==========================================================
    // bus cycles, strobes held 4 low and 3+ high to be seen
    task automatic ext_write(input logic [7:0] d);
        @(posedge ref_clk);
        lvl <= 3'h1;
        drv <= d;
        repeat (4) @(posedge ref_clk);
        lvl <= 3'h7;
        repeat (3) @(posedge ref_clk);
        // released bus must not keep the last word
        drv <= ~d;
        repeat (3) @(posedge ref_clk);
    endtask

    task automatic ext_read(output logic [7:0] d);
        @(posedge ref_clk);
        lvl <= 3'h2;
        repeat (4) @(posedge ref_clk);
        d = bus_lvl;
        lvl <= 3'h7;
        repeat (4) @(posedge ref_clk);
    endtask
endmodule

// File: cpsp_top_test.sv
/*
 * self-checking bench for the control port: register tasks, pin and
 * slave-port scenarios against expected values.
 * assumes the far-side model cpsp_ext_cpu and package cpsp_pkg.
 */
`timescale 1ns/1ps
`define CHECK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin \
    err_count++; $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module cpsp_top_test;
    // ==========================================================
    // signals
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic master_clear_select = 1'b1;
    logic small_package = 1'b0;
    logic ctrl_pin_3 = 1'b1;
    logic [2:0] ctrl_pin_in, ctrl_pin_out, ctrl_pin_oe_n;
    logic master_clear_req, slave_port_irq_flag;
    logic [7:0] psp_data_in, psp_data_out, psp_data_oe_n, rd_word;
    int err_count = 0;
    int cmp_count = 0;
    int irq_cnt = 0;
    int c;

    always #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (slave_port_irq_flag === 1'b1) irq_cnt++;

    cpsp_top DUT (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .master_clear_select(master_clear_select), .small_package(small_package),
        .ctrl_pin_in(ctrl_pin_in), .ctrl_pin_out(ctrl_pin_out),
        .ctrl_pin_oe_n(ctrl_pin_oe_n), .ctrl_pin_3(ctrl_pin_3),
        .master_clear_req(master_clear_req), .psp_data_in(psp_data_in),
        .psp_data_out(psp_data_out), .psp_data_oe_n(psp_data_oe_n),
        .slave_port_irq_flag(slave_port_irq_flag));

    cpsp_ext_cpu cpu (.ref_clk(ref_clk), .pin_out(ctrl_pin_out), .pin_oe_n(ctrl_pin_oe_n),
        .bus_out(psp_data_out), .bus_oe_n(psp_data_oe_n), .pin_lvl(ctrl_pin_in),
        .bus_lvl(psp_data_in));

    // ==========================================================
    // register port tasks
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        `CHECK("reg_rdata", exp, reg_rdata)
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ==========================================================
    // watchdog, the whole sequence needs well under 1000 cycles
    initial begin
        repeat (5000) @(posedge ref_clk);
        err_count++;
        conclude();
    end

    // ==========================================================
    // scenarios
    initial begin
        repeat (5) @(posedge ref_clk);
        resetn <= 1'b1;
        `CHECK("pin_oe_n", 3'h7, ctrl_pin_oe_n)
        `CHECK("master_clear_input_req", 1'b0, master_clear_req)
        rchk(cpsp_pkg::ADDR_DIR_PSP, 8'h07);
        rchk(cpsp_pkg::ADDR_AN_CFG, 8'h00);
        rchk(cpsp_pkg::ADDR_PIN_LEVEL, 8'h00);
        `CHECK("master_clear_input_req", 1'b0, master_clear_req)
        ctrl_pin_3 <= 1'b0;
        repeat (4) @(posedge ref_clk);
        `CHECK("master_clear_input_req", 1'b1, master_clear_req)
        ctrl_pin_3 <= 1'b1;
        wr(cpsp_pkg::ADDR_OUT_LATCH, 8'hFD);
        wr(cpsp_pkg::ADDR_DIR_PSP, 8'h02);
        repeat (2) @(posedge ref_clk);
        `CHECK("pin_oe_n", 3'h2, ctrl_pin_oe_n)
        `CHECK("pin_out", 3'h5, ctrl_pin_out)
        // driven pins still read zero while analog
        rchk(cpsp_pkg::ADDR_PIN_LEVEL, 8'h00);
        wr(cpsp_pkg::ADDR_DIR_PSP, 8'h07);
        wr(cpsp_pkg::ADDR_AN_CFG, 8'hFF);
        rchk(cpsp_pkg::ADDR_AN_CFG, 8'h3F);
        cpu.lvl <= 3'h2;
        master_clear_select <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rchk(cpsp_pkg::ADDR_PIN_LEVEL, 8'h0A);
        rchk(cpsp_pkg::ADDR_OUT_LATCH, 8'h05);
        cpu.lvl <= 3'h7;
        wr(3'h5, 8'hFF);
        rchk(3'h5, 8'h00);
        wr(cpsp_pkg::ADDR_DIR_PSP, 8'hFF);
        rchk(cpsp_pkg::ADDR_DIR_PSP, 8'h17);
        c = irq_cnt;
        cpu.ext_write(8'h5A);
        rchk(cpsp_pkg::ADDR_DIR_PSP, 8'h97);
        `CHECK("irq_count", c + 1, irq_cnt)
        rchk(cpsp_pkg::ADDR_PSP_DATA, 8'h5A);
        rchk(cpsp_pkg::ADDR_DIR_PSP, 8'h17);
        cpu.ext_write(8'h3C);
        cpu.ext_write(8'hC5);
        rchk(cpsp_pkg::ADDR_DIR_PSP, 8'hB7);
        wr(cpsp_pkg::ADDR_DIR_PSP, 8'h37);
        rchk(cpsp_pkg::ADDR_DIR_PSP, 8'hB7);
        rchk(cpsp_pkg::ADDR_PSP_DATA, 8'h3C);
        wr(cpsp_pkg::ADDR_DIR_PSP, 8'h17);
        rchk(cpsp_pkg::ADDR_DIR_PSP, 8'h17);
        wr(cpsp_pkg::ADDR_PSP_DATA, 8'hC3);
        rchk(cpsp_pkg::ADDR_DIR_PSP, 8'h57);
        c = irq_cnt;
        cpu.ext_read(rd_word);
        `CHECK("ext_read", 8'hC3, rd_word)
        `CHECK("irq_count", c + 1, irq_cnt)
        rchk(cpsp_pkg::ADDR_DIR_PSP, 8'h17);
        small_package <= 1'b1;
        wr(cpsp_pkg::ADDR_DIR_PSP, 8'h00);
        repeat (2) @(posedge ref_clk);
        `CHECK("pin_oe_n", 3'h7, ctrl_pin_oe_n)
        rchk(cpsp_pkg::ADDR_PIN_LEVEL, 8'h08);
        conclude();
    end
endmodule
